// >>> hw/hbp_pkg.sv
package hbp_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int DT_DELAY_NS   = 125;
    localparam int DT_MIN_NS     = 325;
    localparam int DT_DELAY_CYC  = (DT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DT_MIN_CYC    = (DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_OSC_CYC  = 10;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic osc_ramp_fall;
        logic pwm_trip;
        logic ocp_trip;
        logic latched_disable_input;
        logic comp_below_low;
        logic comp_above_high;
    } hbp_sense_t;

    typedef struct packed {
        logic vcc_uvlo;
        logic vcc_at_start;
        logic vcc_below_restart;
        logic vcc_below_start_hyst;
    } hbp_supply_t;

    typedef enum logic [2:0] {
        PH_OFF   = 3'b000,
        PH_BOOT  = 3'b001,
        PH_LS    = 3'b010,
        PH_DT_HS = 3'b011,
        PH_HS    = 3'b100,
        PH_DT_LS = 3'b101
    } hbp_phase_t;

    typedef enum logic [1:0] {
        PROT_IDLE = 2'b00,
        PROT_WARN = 2'b01,
        PROT_SHUT = 2'b10
    } hbp_prot_t;

    typedef struct packed {
        logic       ramp_d;
        logic       tog;
        hbp_phase_t phase;
        hbp_prot_t  prot;
        logic       warn_stage;
        logic       pwm_done;
        logic       run;
        logic       boot_done;
        logic [3:0] boot_cnt;
        logic       burst;
        logic       dis;
        logic       dis_gen;
        logic       gen_block;
        logic       hs;
        logic       ls;
    } hbp_state_t;

    typedef struct packed {
        logic       ramp_d;
        logic [7:0] meas;
        logic [7:0] ramp_len;
        logic [8:0] cnt;
        logic       busy;
    } hbp_dt_state_t;

endpackage

// >>> hw/hbp_dead_timer.sv
module hbp_dead_timer
    import hbp_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic ramp,
    input  wire logic start,
    output logic      done
);

    localparam logic [8:0] DELAY_C = 9'(DT_DELAY_CYC);
    localparam logic [8:0] MIN_C   = 9'(DT_MIN_CYC);

    hbp_dt_state_t st_ff;
    hbp_dt_state_t nxt_st;
    logic [8:0]    total;

    // Dead time tracks the last measured falling ramp plus the fixed delay
    always_comb begin
        total = {1'b0, st_ff.ramp_len} + DELAY_C;
        if (total < MIN_C) begin
            total = MIN_C;
        end
    end

    assign done = st_ff.busy && (st_ff.cnt == 9'h000);

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.ramp_d = ramp;
        if (ramp) begin
            if (st_ff.meas != 8'hFF) begin
                nxt_st.meas = st_ff.meas + 8'h01;
            end
        end else if (st_ff.ramp_d) begin
            nxt_st.ramp_len = st_ff.meas;
            nxt_st.meas     = 8'h00;
        end
        if (start) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt  = total;
        end else if (done) begin
            nxt_st.busy = 1'b0;
        end else if (st_ff.busy) begin
            nxt_st.cnt = st_ff.cnt - 9'h001;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// >>> hw/hbp_sequencer.sv
// Operation
// - Current reaching control level ends high-side on-time, at most once per cycle.
// - Sense above 1.5 V flags an overcurrent fault.
// - First fault trip enters a warning state, not shutdown.
// - No trip next cycle returns to idle; a second trip latches shutdown.
// - Overcurrent shutdown holds until supply drops below undervoltage lockout.
// - After that clear, start-up generator stays off until restart level reached.
// - Disable input above 4.5 V shuts down at once into low power.
// - Disable latch clears only by supply undervoltage.
// - While disabled, start-up generator cycles supply between start and start minus 1 V.
// - One oscillator pulse per falling sawtooth ramp.
// - Toggle splits oscillator pulses into alternating odd and even.
// - Even pulse turns low side off, high side on after dead time.
// - Control comparator ends high side; low side on after dead time.
// - Overcurrent comparator ends high side under overload.
// - Next odd pulse forces high side off, duty below 50 %.
// - Switching period equals two oscillator periods.
// - Start-up holds low side for 10 oscillator cycles before high side.
// - Burst resume: first pulse low side, high side after second pulse.
// - Dead time equals falling-ramp duration plus 125 ns.
// - Dead time never below 325 ns.
// - Control below 1.75 V idles drives and oscillator; resume above 1.82 V.
module hbp_sequencer
    import hbp_pkg::*;
#(
    parameter int BOOT_CYCLES = BOOT_OSC_CYC
)
(
    input  wire logic  core_clk,
    input  wire logic  arst_n,
    input  hbp_sense_t sense,
    input  hbp_supply_t supply,
    output logic       hs_drive,
    output logic       ls_drive,
    output logic       startup_generator_enable,
    output logic       osc_run,
    output logic       low_power,
    output logic       ocp_warning,
    output logic       ocp_latched,
    output logic       disable_latched
);

    localparam logic [3:0] BOOT_LAST = 4'(BOOT_CYCLES - 1);

    hbp_state_t s_ff;
    hbp_state_t nxt_s;
    logic       pulse;
    logic       even_p;
    logic       odd_p;
    logic       stop;
    logic       hs_end;
    logic       dt_start;
    logic       dt_done;

    // ----------------------------------------------------------------
    // Clock pulse split
    // ----------------------------------------------------------------
    assign pulse  = sense.osc_ramp_fall && !s_ff.ramp_d && !stop;
    assign even_p = pulse && s_ff.tog;
    assign odd_p  = pulse && !s_ff.tog;

    assign stop   = !s_ff.run || s_ff.burst || s_ff.dis || (s_ff.prot == PROT_SHUT);
    assign hs_end = sense.pwm_trip || sense.ocp_trip || odd_p;

    hbp_dead_timer u_dead_timer (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .ramp     (sense.osc_ramp_fall),
        .start    (dt_start),
        .done     (dt_done)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s        = s_ff;
        dt_start     = 1'b0;
        nxt_s.ramp_d = sense.osc_ramp_fall;
        nxt_s.tog    = s_ff.tog ^ pulse;

        // Supply supervision acts as the functional reset of the latches
        if (supply.vcc_uvlo) begin
            nxt_s.run        = 1'b0;
            nxt_s.boot_done  = 1'b0;
            nxt_s.dis        = 1'b0;
            nxt_s.dis_gen    = 1'b0;
            nxt_s.prot       = PROT_IDLE;
            nxt_s.warn_stage = 1'b0;
            if (s_ff.prot == PROT_SHUT) begin
                nxt_s.gen_block = 1'b1;
            end
        end else if (supply.vcc_at_start && !s_ff.gen_block) begin
            nxt_s.run = 1'b1;
        end
        if (supply.vcc_below_restart) begin
            nxt_s.gen_block = 1'b0;
        end

        // Disable latch; generator is pulsed to keep the latch alive
        if (sense.latched_disable_input && !supply.vcc_uvlo) begin
            nxt_s.dis = 1'b1;
        end
        if (s_ff.dis) begin
            if (supply.vcc_below_start_hyst) begin
                nxt_s.dis_gen = 1'b1;
            end else if (supply.vcc_at_start) begin
                nxt_s.dis_gen = 1'b0;
            end
        end

        // Burst hysteresis on the control voltage
        if (sense.comp_below_low) begin
            nxt_s.burst = 1'b1;
        end else if (sense.comp_above_high) begin
            nxt_s.burst = 1'b0;
        end

        // Two-strike overcurrent protection
        if (s_ff.run && !supply.vcc_uvlo) begin
            unique case (s_ff.prot)
                PROT_IDLE: begin
                    if (sense.ocp_trip) begin
                        nxt_s.prot       = PROT_WARN;
                        nxt_s.warn_stage = 1'b0;
                    end
                end
                PROT_WARN: begin
                    if (sense.ocp_trip && s_ff.warn_stage) begin
                        nxt_s.prot = PROT_SHUT;
                    end else if (even_p) begin
                        // A trip spread over the first cycle counts once
                        if (s_ff.warn_stage) begin
                            nxt_s.prot       = PROT_IDLE;
                            nxt_s.warn_stage = 1'b0;
                        end else begin
                            nxt_s.warn_stage = 1'b1;
                        end
                    end
                end
                PROT_SHUT: begin
                    nxt_s.prot = PROT_SHUT;
                end
                default: begin
                    nxt_s.prot = PROT_SHUT;
                end
            endcase
        end

        // Gate drive sequencing
        if (stop) begin
            nxt_s.phase    = PH_OFF;
            nxt_s.hs       = 1'b0;
            nxt_s.ls       = 1'b0;
            nxt_s.tog      = 1'b0;
            nxt_s.pwm_done = 1'b0;
        end else begin
            unique case (s_ff.phase)
                PH_OFF: begin
                    if (pulse) begin
                        nxt_s.ls       = 1'b1;
                        nxt_s.boot_cnt = 4'h0;
                        nxt_s.phase    = s_ff.boot_done ? PH_LS : PH_BOOT;
                    end
                end
                PH_BOOT: begin
                    if (pulse) begin
                        if (s_ff.boot_cnt == BOOT_LAST) begin
                            nxt_s.boot_done = 1'b1;
                            nxt_s.ls        = 1'b0;
                            nxt_s.tog       = 1'b0;
                            nxt_s.phase     = PH_DT_HS;
                            dt_start        = 1'b1;
                        end else begin
                            nxt_s.boot_cnt = s_ff.boot_cnt + 4'h1;
                        end
                    end
                end
                PH_LS: begin
                    if (even_p) begin
                        nxt_s.ls    = 1'b0;
                        nxt_s.phase = PH_DT_HS;
                        dt_start    = 1'b1;
                    end
                end
                PH_DT_HS: begin
                    if (dt_done) begin
                        nxt_s.hs       = 1'b1;
                        nxt_s.pwm_done = 1'b0;
                        nxt_s.phase    = PH_HS;
                    end
                end
                PH_HS: begin
                    if (hs_end) begin
                        nxt_s.hs       = 1'b0;
                        nxt_s.pwm_done = sense.pwm_trip;
                        nxt_s.phase    = PH_DT_LS;
                        dt_start       = 1'b1;
                    end
                end
                PH_DT_LS: begin
                    if (dt_done) begin
                        nxt_s.ls    = 1'b1;
                        nxt_s.phase = PH_LS;
                    end
                end
                default: begin
                    nxt_s.phase = PH_OFF;
                    nxt_s.hs    = 1'b0;
                    nxt_s.ls    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hs_drive                 = s_ff.hs;
    assign ls_drive                 = s_ff.ls;
    assign startup_generator_enable = s_ff.dis ? s_ff.dis_gen : (!s_ff.run && !s_ff.gen_block);
    assign osc_run                  = !stop;
    assign low_power                = s_ff.dis || s_ff.burst || (s_ff.prot == PROT_SHUT);
    assign ocp_warning              = (s_ff.prot == PROT_WARN);
    assign ocp_latched              = (s_ff.prot == PROT_SHUT);
    assign disable_latched          = s_ff.dis;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [6:0] both_off_cnt_ff;
    logic [3:0] even_gap_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Drives are off from reset on, so the first turn-on is not a dead-time violation
            both_off_cnt_ff <= 7'h7F;
            even_gap_ff     <= 4'h0;
        end else begin
            if (s_ff.hs || s_ff.ls) begin
                both_off_cnt_ff <= 7'h00;
            end else if (both_off_cnt_ff != 7'h7F) begin
                both_off_cnt_ff <= both_off_cnt_ff + 7'h01;
            end
            if (even_p || stop) begin
                even_gap_ff <= 4'h0;
            end else if (pulse && even_gap_ff != 4'hF) begin
                even_gap_ff <= even_gap_ff + 4'h1;
            end
        end
    end

    chk_no_overlap: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(hs_drive && ls_drive))
        else $error("both drives on together");

    chk_stop_drives: assert property (@(posedge core_clk) disable iff (!arst_n)
        stop |=> !hs_drive && !ls_drive)
        else $error("drive on while stopped");

    chk_dead_min: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(hs_drive) || $rose(ls_drive) |-> both_off_cnt_ff >= 7'(DT_MIN_CYC))
        else $error("dead time shorter than minimum");

    chk_pwm_once: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_ff.phase == PH_HS && sense.pwm_trip && !stop |=> !hs_drive ##0 s_ff.pwm_done)
        else $error("pwm trip did not end on-time");

    chk_odd_limit: assert property (@(posedge core_clk) disable iff (!arst_n)
        odd_p && hs_drive |=> !hs_drive)
        else $error("odd pulse did not end on-time");

    chk_even_every: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_ff.boot_done && s_ff.phase != PH_OFF |-> even_gap_ff <= 4'h2)
        else $error("even pulse missing in switching period");

    chk_ocp_warn: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_ff.run && !supply.vcc_uvlo && s_ff.prot == PROT_IDLE && sense.ocp_trip |=> ocp_warning && !ocp_latched)
        else $error("first trip did not warn");

    chk_ocp_shut: assert property (@(posedge core_clk) disable iff (!arst_n)
        !supply.vcc_uvlo && ocp_warning && s_ff.warn_stage && sense.ocp_trip |=> ocp_latched ##1 !hs_drive)
        else $error("second trip did not latch");

    chk_ocp_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        ocp_latched && !supply.vcc_uvlo |=> ocp_latched)
        else $error("overcurrent latch lost");

    chk_dis_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        disable_latched && !supply.vcc_uvlo |=> disable_latched && low_power)
        else $error("disable latch lost");

    chk_hiccup_block: assert property (@(posedge core_clk) disable iff (!arst_n)
        ocp_latched && supply.vcc_uvlo && !supply.vcc_below_restart && !disable_latched
        |=> !startup_generator_enable)
        else $error("generator enabled before restart level");

    cov_high_on:   cover property (@(posedge core_clk) disable iff (!arst_n) $rose(hs_drive));
    cov_ocp_shut:  cover property (@(posedge core_clk) disable iff (!arst_n) $rose(ocp_latched));
    cov_warn_back: cover property (@(posedge core_clk) disable iff (!arst_n) $fell(ocp_warning) && !ocp_latched);
    cov_resume:    cover property (@(posedge core_clk) disable iff (!arst_n)
        s_ff.boot_done && $fell(s_ff.burst));

endmodule

// >>> dv/hbp_gate_model.sv
module hbp_gate_model
    import hbp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        hs_drive,
    input  wire logic        ls_drive,
    output logic [15:0]      gap,
    output logic             overlap
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Gate pair: both-off time before each turn-on, and overlap
    // ----------------------------------------------------------------
    logic [15:0] idle_ff;

    // Gap holds the last both-off stretch, so a stop period also lands here
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_ff <= 16'h0000;
            gap     <= 16'h0000;
            overlap <= 1'b0;
        end else begin
            if (!hs_drive && !ls_drive) begin
                idle_ff <= idle_ff + 16'h0001;
            end else begin
                if (idle_ff != 16'h0000) begin
                    gap <= idle_ff;
                end
                idle_ff <= 16'h0000;
            end
            if (hs_drive && ls_drive) begin
                overlap <= 1'b1;
            end
        end
    end
endmodule

// >>> dv/testbench.sv
module testbench
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Setup
    // ----------------------------------------------------------------
    localparam int BOOT = 2;
    localparam int PER  = 160;
    localparam int TMAX = 20000;

    logic        core_clk;
    logic        arst_n;
    hbp_sense_t  sense;
    hbp_supply_t supply;
    logic        hs_drive;
    logic        ls_drive;
    logic        startup_generator_enable;
    logic        osc_run;
    logic        low_power;
    logic        ocp_warning;
    logic        ocp_latched;
    logic        disable_latched;
    logic [15:0] gap;
    logic        overlap;
    int          fail_count;
    int          compares;
    int          cyc = 0;

    hbp_sequencer #(.BOOT_CYCLES(BOOT)) u_dut (
        .core_clk                (core_clk),
        .arst_n                  (arst_n),
        .sense                   (sense),
        .supply                  (supply),
        .hs_drive                (hs_drive),
        .ls_drive                (ls_drive),
        .startup_generator_enable(startup_generator_enable),
        .osc_run                 (osc_run),
        .low_power               (low_power),
        .ocp_warning             (ocp_warning),
        .ocp_latched             (ocp_latched),
        .disable_latched         (disable_latched)
    );

    hbp_gate_model u_gate (
        .core_clk(core_clk),
        .arst_n  (arst_n),
        .hs_drive(hs_drive),
        .ls_drive(ls_drive),
        .gap     (gap),
        .overlap (overlap)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task results;
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == TMAX) begin
            fail_count++;
            results();
        end
    end

    task chk(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            fail_count++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask

    // Settled sampling point just after the edge
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One oscillator period; ramp high for len cycles
    task pulse(input int len);
        @(posedge core_clk);
        sense.osc_ramp_fall <= 1'b1;
        repeat (len) @(posedge core_clk);
        sense.osc_ramp_fall <= 1'b0;
        tick(PER - len - 1);
    endtask

    // Both-off time may exceed the timer load by the two register stages
    task chk_gap(input int t, input string msg);
        chk(gap >= t && gap <= t + 2, msg);
    endtask

    task trip_ocp;
        @(posedge core_clk);
        sense.ocp_trip <= 1'b1;
        @(posedge core_clk);
        sense.ocp_trip <= 1'b0;
        tick(3);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task s_boot;
        @(posedge core_clk);
        supply.vcc_at_start <= 1'b1;
        tick(3);
        pulse(4);
        chk(ls_drive === 1'b1 && hs_drive === 1'b0, "boot low side");
        repeat (BOOT - 1) pulse(4);
        chk(hs_drive === 1'b0, "high side before boot end");
        pulse(4);
        chk(hs_drive === 1'b1 && ls_drive === 1'b0, "high side after boot");
        chk_gap(DT_MIN_CYC, "minimum dead time");
    endtask

    task s_odd;
        pulse(4);
        chk(hs_drive === 1'b0 && ls_drive === 1'b1, "odd pulse end");
        pulse(4);
        chk(hs_drive === 1'b1 && ls_drive === 1'b0, "even pulse start");
        chk_gap(DT_MIN_CYC, "even dead time");
    endtask

    task s_trip;
        @(posedge core_clk);
        sense.pwm_trip <= 1'b1;
        tick(2);
        chk(hs_drive === 1'b0, "control trip end");
        tick(100);
        chk(ls_drive === 1'b1 && hs_drive === 1'b0, "single turn-off");
        chk_gap(DT_MIN_CYC, "trip dead time");
        @(posedge core_clk);
        sense.pwm_trip <= 1'b0;
        pulse(4);
        chk(hs_drive === 1'b0, "odd pulse in low side");
        pulse(4);
        chk(hs_drive === 1'b1, "next period start");
    endtask

    task s_ramp;
        pulse(60);
        pulse(60);
        chk_gap(60 + DT_DELAY_CYC, "ramp dead time");
        pulse(4);
        pulse(4);
    endtask

    task s_warn;
        trip_ocp();
        chk(hs_drive === 1'b0 && ocp_warning === 1'b1, "warning entry");
        chk(ocp_latched === 1'b0, "first trip no stop");
        repeat (4) pulse(4);
        chk(ocp_warning === 1'b0 && hs_drive === 1'b1, "warning clear");
    endtask

    task s_latch;
        trip_ocp();
        pulse(4);
        pulse(4);
        tick(10);
        trip_ocp();
        chk(ocp_latched === 1'b1 && osc_run === 1'b0, "second trip");
        chk(hs_drive === 1'b0 && ls_drive === 1'b0, "drives off");
        pulse(4);
        chk(ocp_latched === 1'b1 && ls_drive === 1'b0, "latch holds");
        @(posedge core_clk);
        supply.vcc_at_start <= 1'b0;
        supply.vcc_uvlo     <= 1'b1;
        tick(3);
        chk(ocp_latched === 1'b0, "uvlo clears");
        chk(startup_generator_enable === 1'b0, "generator held");
        @(posedge core_clk);
        supply.vcc_below_restart <= 1'b1;
        tick(3);
        chk(startup_generator_enable === 1'b1, "restart level");
        @(posedge core_clk);
        supply.vcc_below_restart <= 1'b0;
        supply.vcc_uvlo          <= 1'b0;
        s_boot();
    endtask

    task s_burst;
        @(posedge core_clk);
        sense.comp_below_low  <= 1'b1;
        sense.comp_above_high <= 1'b0;
        tick(3);
        chk(hs_drive === 1'b0 && ls_drive === 1'b0, "burst idle");
        chk(osc_run === 1'b0 && low_power === 1'b1, "burst osc stop");
        pulse(4);
        chk(ls_drive === 1'b0, "pulse ignored idle");
        @(posedge core_clk);
        sense.comp_below_low  <= 1'b0;
        sense.comp_above_high <= 1'b1;
        tick(3);
        chk(osc_run === 1'b1, "burst resume");
        pulse(4);
        chk(ls_drive === 1'b1 && hs_drive === 1'b0, "resume low side");
        pulse(4);
        chk(hs_drive === 1'b1, "resume high side");
    endtask

    task s_disable;
        @(posedge core_clk);
        sense.latched_disable_input <= 1'b1;
        tick(3);
        chk(hs_drive === 1'b0 && ls_drive === 1'b0, "disable stop");
        chk(disable_latched === 1'b1 && low_power === 1'b1, "disable low power");
        @(posedge core_clk);
        sense.latched_disable_input <= 1'b0;
        supply.vcc_at_start         <= 1'b0;
        supply.vcc_below_start_hyst <= 1'b1;
        tick(3);
        chk(disable_latched === 1'b1, "disable held");
        chk(startup_generator_enable === 1'b1, "generator on low");
        @(posedge core_clk);
        supply.vcc_below_start_hyst <= 1'b0;
        supply.vcc_at_start         <= 1'b1;
        tick(3);
        chk(startup_generator_enable === 1'b0, "generator off high");
        @(posedge core_clk);
        supply.vcc_uvlo <= 1'b1;
        tick(3);
        chk(disable_latched === 1'b0, "uvlo clears disable");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        fail_count = 0;
        compares   = 0;
        arst_n     = 1'b0;
        sense      = '0;
        supply     = '0;
        sense.comp_above_high = 1'b1;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        s_boot();
        s_odd();
        s_trip();
        s_ramp();
        s_warn();
        s_latch();
        s_burst();
        s_disable();
        chk(overlap === 1'b0, "drives overlapped");
        results();
    end
endmodule
